// ===== hpamux_defs.svh
// Constants for the shared host-port / audio pin multiplexer.
// Assumes it is included by bare name from the package and the modules.
`ifndef HPAMUX_DEFS_SVH
`define HPAMUX_DEFS_SVH

// Number of shared pins handled by the mux
`define HPAMUX_NPINS        12
// Pin positions in the pad vectors
`define HPAMUX_PIN_D6       0
`define HPAMUX_PIN_D5       1
`define HPAMUX_PIN_D4       2
`define HPAMUX_PIN_D3       3
`define HPAMUX_PIN_D2       4
`define HPAMUX_PIN_D1       5
`define HPAMUX_PIN_D0       6
`define HPAMUX_PIN_ASTB     7
`define HPAMUX_PIN_CSEL     8
`define HPAMUX_PIN_STB1     9
`define HPAMUX_PIN_STB2     10
`define HPAMUX_PIN_RDY      11
// Number of host data bits that share pins
`define HPAMUX_HD_BITS      7
// Reset values
`define HPAMUX_OE_N_RST     12'hFFF
`define HPAMUX_OUT_RST      12'h000
`define HPAMUX_STB_N_IDLE   4'hF
`define HPAMUX_HD_IDLE      7'h00
`define HPAMUX_AUD_IDLE     12'h000
// Strap level that selects the host port (pull-up default)
`define HPAMUX_STRAP_HOST   1'b1

`endif

// ===== hpamux_pkg.sv
// Types shared by the pin multiplexer modules.
// Assumes hpamux_defs.svh is on the include path.
`include "hpamux_defs.svh"
package hpamux_pkg;
    // Strap capture states
    typedef enum logic [1:0] {
        HPAMUX_ST_HOLD = 2'b00,
        HPAMUX_ST_RUN  = 2'b01
    } hpamux_state_t;
endpackage

// ===== hpamux_mode_if.sv
// Carries the captured pin mode from the strap logic to the mux.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface hpamux_mode_if;
    logic host_mode;  // High: host port owns pins; low: audio port
    logic mode_valid; // High once the strap has been captured
    modport src (output host_mode, output mode_valid);
    modport snk (input host_mode, input mode_valid);
endinterface
`default_nettype wire

// ===== hpamux_strap.sv
// Captures the host/audio select strap once after reset release.
// Assumes the strap level is steady on the first edge after reset.
`timescale 1ns/1ps
`default_nettype none
`include "hpamux_defs.svh"
module hpamux_strap
    import hpamux_pkg::*;
(
    input  wire logic     clk,
    input  wire logic     rst,
    input  wire logic     host_port_select_strap,
    hpamux_mode_if.src    mode
);
    hpamux_state_t state_ff;     // Capture state
    hpamux_state_t nxt_state;
    logic          host_ff;      // Captured mode
    logic          nxt_host;
    logic          valid_ff;     // Mode is known
    logic          nxt_valid;

    // Sample the strap on the first edge after reset, then hold
    always_comb
    begin
        nxt_state = state_ff;
        nxt_host  = host_ff;
        nxt_valid = valid_ff;
        case (state_ff)
            HPAMUX_ST_HOLD:
            begin
                nxt_host  = host_port_select_strap; // [R11]
                nxt_valid = 1'b1;
                nxt_state = HPAMUX_ST_RUN;
            end
            default:
            begin
                nxt_state = HPAMUX_ST_RUN;
            end
        endcase
    end

    // Registers; host mode is the reset default
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_ff <= HPAMUX_ST_HOLD;
            host_ff  <= `HPAMUX_STRAP_HOST; // [R11]
            valid_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            host_ff  <= nxt_host;
            valid_ff <= nxt_valid;
        end
    end

    assign mode.host_mode  = host_ff;
    assign mode.mode_valid = valid_ff;

    // Strap level is taken one edge after release
    // The release edge itself still sees reset values, so skip it
    strap_capture_a: assert property ( // [R11]
        @(posedge clk) disable iff (rst)
        !rst && state_ff == HPAMUX_ST_HOLD
        |=> host_ff == $past(host_port_select_strap) && valid_ff)
        else $error("strap not captured");
    // Mode never changes once valid
    mode_hold_a: assert property ( // [R11]
        @(posedge clk) disable iff (rst)
        valid_ff |=> $stable(host_ff) && valid_ff)
        else $error("mode changed after capture");
endmodule // hpamux_strap
`default_nettype wire

// ===== hpamux_top.sv
// Shared pin multiplexer between the 16-bit host port and the second
// audio serial port, with a general-purpose option on one pin.
// Assumes pad cells resolve pad_out/pad_oe_n onto the pins.
// Function
// (R1) Pin 0: host data 6 or rx master clock
// (R2) Pin 1: host data 5 or tx master clock
// (R3) Pin 2: host data 4 or general-purpose bit
// (R4) Pin 3: host data 3 or mute output
// (R5) Pin 4: host data 2 or tx frame sync
// (R6) Pins 5,6: host data 1,0 or lanes 7,4
// (R7) Pin 7: address strobe or tx bit clock
// (R8) Pin 8: chip select or lane 2
// (R9) Pins 9,10: data strobes or lanes 6,5
// (R10) Pin 11: host ready or rx bit clock
// (R11) Strap at reset picks mode, host default
// (R12) Unselected function undriven, inputs held inactive
`timescale 1ns/1ps
`default_nettype none
`include "hpamux_defs.svh"
module hpamux_top
    import hpamux_pkg::*;
(
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      host_port_select_strap,
    input  wire logic                      gp0_select,
    input  wire logic [`HPAMUX_NPINS-1:0]  pad_in,
    output logic      [`HPAMUX_NPINS-1:0]  pad_out_ff,
    output logic      [`HPAMUX_NPINS-1:0]  pad_oe_n_ff,
    input  wire logic [`HPAMUX_HD_BITS-1:0] host_data_out,
    input  wire logic [`HPAMUX_HD_BITS-1:0] host_data_drive,
    output logic      [`HPAMUX_HD_BITS-1:0] host_data_in_ff,
    output logic                           host_addr_strobe_n_ff,
    output logic                           host_chip_select_n_ff,
    output logic                           host_strobe_one_n_ff,
    output logic                           host_strobe_two_n_ff,
    input  wire logic                      host_ready_out,
    input  wire logic                      host_ready_drive,
    input  wire logic                      general_purpose_bit0_out,
    input  wire logic                      general_purpose_bit0_drive,
    output logic                           general_purpose_bit0_in_ff,
    input  wire logic [`HPAMUX_NPINS-1:0]  audio_out,
    input  wire logic [`HPAMUX_NPINS-1:0]  audio_drive,
    output logic      [`HPAMUX_NPINS-1:0]  audio_in_ff,
    output logic                           host_mode,
    output logic                           mode_valid
);
    // Pin index that carries a given host data bit
    function automatic logic [3:0] hd_pin(input logic [2:0] b);
        hd_pin = 4'(`HPAMUX_PIN_D0) - {1'b0, b};
    endfunction

    hpamux_mode_if mode_bus ();                // Captured mode
    logic [`HPAMUX_NPINS-1:0]  nxt_out;        // Next pad data
    logic [`HPAMUX_NPINS-1:0]  nxt_oe_n;       // Next pad enables
    logic [`HPAMUX_HD_BITS-1:0] nxt_hd_in;     // Next host data in
    logic [3:0]                nxt_stb_n;      // Next strobes, low active
    logic                      nxt_gp_in;      // Next gp input
    logic [`HPAMUX_NPINS-1:0]  nxt_aud_in;     // Next audio inputs
    logic [3:0]                pin;            // Scratch pin index

    // Strap capture
    hpamux_strap u_strap (
        .clk                    (clk),
        .rst                    (rst),
        .host_port_select_strap (host_port_select_strap),
        .mode                   (mode_bus.src)
    );

    assign host_mode  = mode_bus.host_mode;
    assign mode_valid = mode_bus.mode_valid;

    // Route each pin to the function picked by the mode
    always_comb
    begin
        nxt_out    = `HPAMUX_OUT_RST;
        nxt_oe_n   = `HPAMUX_OE_N_RST;           // [R12]
        nxt_hd_in  = `HPAMUX_HD_IDLE;            // [R12]
        nxt_stb_n  = `HPAMUX_STB_N_IDLE;         // [R12]
        nxt_gp_in  = 1'b0;
        nxt_aud_in = `HPAMUX_AUD_IDLE;           // [R12]
        pin        = 4'h0;
        if (mode_bus.mode_valid && mode_bus.host_mode)
        begin
            // Host data bits on pins 0..6 [R1] [R2] [R4] [R5] [R6]
            for (int b = 0; b < `HPAMUX_HD_BITS; b++)
            begin
                pin = hd_pin(3'(b));
                if (!(pin == 4'(`HPAMUX_PIN_D4) && gp0_select))
                begin
                    nxt_hd_in[b]   = pad_in[pin]; // [R3]
                    nxt_out[pin]   = host_data_out[b];
                    nxt_oe_n[pin]  = ~host_data_drive[b];
                end
            end
            // Host control inputs [R7] [R8] [R9]
            nxt_stb_n = {pad_in[`HPAMUX_PIN_STB2], pad_in[`HPAMUX_PIN_STB1],
                         pad_in[`HPAMUX_PIN_CSEL], pad_in[`HPAMUX_PIN_ASTB]};
            // Ready toward the host [R10]
            nxt_out[`HPAMUX_PIN_RDY]  = host_ready_out;
            nxt_oe_n[`HPAMUX_PIN_RDY] = ~host_ready_drive;
        end
        else if (mode_bus.mode_valid)
        begin
            // Audio functions on every pin but the gp pin
            for (int p = 0; p < `HPAMUX_NPINS; p++)
            begin
                if (p != `HPAMUX_PIN_D4)
                begin
                    nxt_out[p]  = audio_out[p];   // [R1] [R2] [R5] [R6]
                    nxt_oe_n[p] = ~audio_drive[p]; // [R7] [R8] [R9] [R10]
                    // Mute is output only, its input stays idle
                    if (p != `HPAMUX_PIN_D3)
                    begin
                        nxt_aud_in[p] = pad_in[p]; // [R4]
                    end
                end
            end
        end
        // General-purpose bit overrides pin 2 in either mode
        if (mode_bus.mode_valid && gp0_select)
        begin
            nxt_out[`HPAMUX_PIN_D4]  = general_purpose_bit0_out; // [R3]
            nxt_oe_n[`HPAMUX_PIN_D4] = ~general_purpose_bit0_drive;
            nxt_gp_in                = pad_in[`HPAMUX_PIN_D4];
        end
    end

    // Register every pad and core-side output
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pad_out_ff                 <= `HPAMUX_OUT_RST;
            pad_oe_n_ff                <= `HPAMUX_OE_N_RST;
            host_data_in_ff            <= `HPAMUX_HD_IDLE;
            host_addr_strobe_n_ff      <= 1'b1;
            host_chip_select_n_ff      <= 1'b1;
            host_strobe_one_n_ff       <= 1'b1;
            host_strobe_two_n_ff       <= 1'b1;
            general_purpose_bit0_in_ff <= 1'b0;
            audio_in_ff                <= `HPAMUX_AUD_IDLE;
        end
        else
        begin
            pad_out_ff                 <= nxt_out;
            pad_oe_n_ff                <= nxt_oe_n;
            host_data_in_ff            <= nxt_hd_in;
            host_addr_strobe_n_ff      <= nxt_stb_n[0];
            host_chip_select_n_ff      <= nxt_stb_n[1];
            host_strobe_one_n_ff       <= nxt_stb_n[2];
            host_strobe_two_n_ff       <= nxt_stb_n[3];
            general_purpose_bit0_in_ff <= nxt_gp_in;
            audio_in_ff                <= nxt_aud_in;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Host data 6 drives pin 0 a cycle later
    host_d6_a: assert property ( // [R1]
        mode_valid && host_mode && host_data_drive[6]
        |=> !pad_oe_n_ff[0] && pad_out_ff[0] == $past(host_data_out[6]))
        else $error("host data 6 not driven");
    // Transmit master clock drives pin 1 in audio mode
    tx_mclk_a: assert property ( // [R2]
        mode_valid && !host_mode && audio_drive[1]
        |=> !pad_oe_n_ff[1] && pad_out_ff[1] == $past(audio_out[1]))
        else $error("tx master clock not driven");
    // General-purpose bit owns pin 2 when selected
    gp_pin_a: assert property ( // [R3]
        mode_valid && gp0_select
        |=> pad_oe_n_ff[2] == $past(!general_purpose_bit0_drive)
        && pad_out_ff[2] == $past(general_purpose_bit0_out)
        && general_purpose_bit0_in_ff == $past(pad_in[2])
        && host_data_in_ff[4] == 1'b0)
        else $error("gp pin routing wrong");
    // Mute pin has no audio input
    mute_out_a: assert property ( // [R4]
        mode_valid && !host_mode
        |=> audio_in_ff[3] == 1'b0
        && pad_oe_n_ff[3] == $past(!audio_drive[3]))
        else $error("mute pin routing wrong");
    // Frame sync input follows pin 4 in audio mode
    fsync_in_a: assert property ( // [R5]
        mode_valid && !host_mode
        |=> audio_in_ff[4] == $past(pad_in[4]))
        else $error("frame sync not captured");
    // Host data bits 1 and 0 read from pins 5 and 6
    host_lo_a: assert property ( // [R6]
        mode_valid && host_mode
        |=> host_data_in_ff[1:0] == {$past(pad_in[5]), $past(pad_in[6])})
        else $error("host data 1,0 wrong");
    // Address strobe reflects pin 7 in host mode
    addr_stb_a: assert property ( // [R7]
        mode_valid && host_mode
        |=> host_addr_strobe_n_ff == $past(pad_in[7]))
        else $error("address strobe wrong");
    // Chip select idles while lane 2 owns pin 8
    csel_idle_a: assert property ( // [R8]
        mode_valid && !host_mode
        |=> host_chip_select_n_ff && audio_in_ff[8] == $past(pad_in[8]))
        else $error("chip select not idle in audio mode");
    // Data strobes follow pins 9 and 10
    strobes_a: assert property ( // [R9]
        mode_valid && host_mode
        |=> host_strobe_one_n_ff == $past(pad_in[9])
        && host_strobe_two_n_ff == $past(pad_in[10]))
        else $error("data strobes wrong");
    // Ready drives pin 11 toward the host
    ready_out_a: assert property ( // [R10]
        mode_valid && host_mode && host_ready_drive
        |=> !pad_oe_n_ff[11] && pad_out_ff[11] == $past(host_ready_out))
        else $error("host ready not driven");
    // Pins stay released until the mode is known
    no_mode_a: assert property ( // [R11]
        !mode_valid
        |=> pad_oe_n_ff == `HPAMUX_OE_N_RST)
        else $error("pin driven before mode capture");
    // Host path idle in audio mode
    host_idle_a: assert property ( // [R12]
        mode_valid && !host_mode && !gp0_select
        |=> host_data_in_ff == `HPAMUX_HD_IDLE && pad_oe_n_ff[2])
        else $error("host path active in audio mode");
    // Audio inputs idle while the host port owns the pins
    audio_idle_a: assert property ( // [R12]
        mode_valid && host_mode
        |=> audio_in_ff == `HPAMUX_AUD_IDLE)
        else $error("audio path active in host mode");

    // Main scenarios
    host_drive_c: cover property (mode_valid && host_mode && host_data_drive[0]);
    audio_drive_c: cover property (mode_valid && !host_mode && audio_drive[11]);
    gp_drive_c: cover property (mode_valid && gp0_select
        && general_purpose_bit0_drive);
    audio_in_c: cover property (mode_valid && !host_mode && !audio_drive[8]
        && pad_in[8]);
endmodule // hpamux_top
`default_nettype wire

// ===== hpamux_far_model.sv
// Far-side model: external host or audio converters on the shared pins.
// Assumes the device drives pad_out_ff wherever pad_oe_n_ff is low.
`timescale 1ns/1ps
`default_nettype none
module hpamux_far_model
#(
    parameter logic [11:0] PULL_UP = 12'h7FB  // Pull-up pins; others pull down
)
(
    input  wire logic [11:0] far_val,
    input  wire logic [11:0] far_en,
    input  wire logic        strap_en,
    input  wire logic        strap_val,
    input  wire logic [11:0] pad_out_ff,
    input  wire logic [11:0] pad_oe_n_ff,
    output logic      [11:0] pad_in,
    output logic             strap
);
    // Unstrapped select pin rests on its pull-up, which means host mode
    assign strap = strap_en ? strap_val : 1'b1;
    // Resolve each pin from both enables; a clash reads unknown
    always_comb
    begin
        for (int i = 0; i < 12; i++)
        begin
            if (!pad_oe_n_ff[i] && far_en[i])
                pad_in[i] = 1'bx;
            else if (!pad_oe_n_ff[i])
                pad_in[i] = pad_out_ff[i];
            else if (far_en[i])
                pad_in[i] = far_val[i];
            else
                pad_in[i] = PULL_UP[i];
        end
    end
endmodule // hpamux_far_model
`default_nettype wire

// ===== hpamux_tb.sv
// Self-checking bench for the shared host/audio pin multiplexer.
// Assumes the far-side model resolves the pins and the select strap.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import hpamux_pkg::*;
    logic        clk, rst, gp0_select, strap_en, strap_val, strap;
    logic        rdy_out, rdy_drive, gp_out, gp_drive, gp_in;
    logic        astb_n, csel_n, stb1_n, stb2_n, host_mode, mode_valid;
    logic [6:0]  hd_out, hd_drive, hd_in;    // Host core data side
    logic [11:0] aud_out, aud_drive, aud_in; // Audio core side
    logic [11:0] far_val, far_en;            // Far side drive request
    logic [11:0] pad_in, pad_out, pad_oe_n;  // Pin levels and device drive
    int          bad_count, compares;

    hpamux_top hpamux_top_i (.clk(clk), .rst(rst),
        .host_port_select_strap(strap), .gp0_select(gp0_select),
        .pad_in(pad_in), .pad_out_ff(pad_out), .pad_oe_n_ff(pad_oe_n),
        .host_data_out(hd_out), .host_data_drive(hd_drive),
        .host_data_in_ff(hd_in), .host_addr_strobe_n_ff(astb_n),
        .host_chip_select_n_ff(csel_n), .host_strobe_one_n_ff(stb1_n),
        .host_strobe_two_n_ff(stb2_n), .host_ready_out(rdy_out),
        .host_ready_drive(rdy_drive), .general_purpose_bit0_out(gp_out),
        .general_purpose_bit0_drive(gp_drive),
        .general_purpose_bit0_in_ff(gp_in), .audio_out(aud_out),
        .audio_drive(aud_drive), .audio_in_ff(aud_in),
        .host_mode(host_mode), .mode_valid(mode_valid));
    hpamux_far_model hpamux_far_model_i (.far_val(far_val), .far_en(far_en),
        .strap_en(strap_en), .strap_val(strap_val), .pad_out_ff(pad_out),
        .pad_oe_n_ff(pad_oe_n), .pad_in(pad_in), .strap(strap));

    // 250 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Host data bit b sits on pin 6-b
    function automatic logic [6:0] rev7(logic [6:0] v);
        logic [6:0] r;
        for (int i = 0; i < 7; i++)
            r[i] = v[6-i];
        return r;
    endfunction

    // Compare one value, report and count
    task automatic chk(string name, logic [11:0] exp, logic [11:0] got);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Let the one-cycle registered answer land
    task automatic settle();
        @(posedge clk);
        #1;
    endtask

    // Reset with the strap driven or left floating, then check capture
    task automatic do_reset(logic en, logic val);
        @(posedge clk);
        rst <= 1'b1;
        strap_en <= en;
        strap_val <= val;
        repeat (8) @(posedge clk);
        #1;
        chk("oe_n in reset", 12'hFFF, pad_oe_n);
        chk("valid in reset", 12'h000, 12'(mode_valid));
        @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk("mode valid", 12'h001, 12'(mode_valid));
        chk("mode", 12'(en ? val : 1'b1), 12'(host_mode));
    endtask

    // Host mode outputs, partial data drive, audio drive ignored
    task automatic host_out();
        logic [11:0] oe, m;
        @(posedge clk);
        hd_out <= 7'h55;
        hd_drive <= 7'h3A;
        rdy_out <= 1'b1;
        rdy_drive <= 1'b1;
        aud_out <= 12'h000;
        aud_drive <= 12'hFFF;
        settle();
        oe = {1'b0, 4'hF, ~rev7(7'h3A)};
        m = ~oe;
        chk("host oe_n", oe, pad_oe_n);
        chk("host out", {1'b1, 4'h0, rev7(7'h55)} & m, pad_out & m);
    endtask

    // Far host drives data pins and strobes; inputs must follow
    task automatic host_in(logic [11:0] v);
        @(posedge clk);
        hd_drive <= 7'h00;
        rdy_drive <= 1'b0;
        // Far host drives only once the device has let go
        @(posedge clk);
        far_en <= 12'h7FF;
        far_val <= v;
        settle();
        chk("host data in", 12'(rev7(v[6:0])), 12'(hd_in));
        chk("strobes", 12'(v[10:7]), 12'({stb2_n, stb1_n, csel_n, astb_n}));
        chk("audio in idle", 12'h000, aud_in);
        chk("ready undriven", 12'h001, 12'(pad_oe_n[11]));
    endtask

    // General-purpose use of pin 2, overriding host data 4
    task automatic gp_test();
        @(posedge clk);
        far_en <= 12'h000;
        gp0_select <= 1'b1;
        gp_out <= 1'b1;
        gp_drive <= 1'b1;
        hd_out <= 7'h00;
        hd_drive <= 7'h10;
        settle();
        chk("gp drive", 12'h001, 12'({pad_oe_n[2], pad_out[2]}));
        @(posedge clk);
        gp_drive <= 1'b0;
        @(posedge clk);
        far_en <= 12'h004;
        far_val <= 12'h004;
        settle();
        chk("gp in", 12'h001, 12'(gp_in));
        chk("gp pin data4 idle", 12'h000, 12'(hd_in[4]));
        @(posedge clk);
        gp0_select <= 1'b0;
        far_en <= 12'h000;
        hd_drive <= 7'h00;
    endtask

    // Audio mode: audio owns pins, mute three-states, host ignored
    task automatic audio_test();
        @(posedge clk);
        hd_drive <= 7'h7F;
        rdy_drive <= 1'b1;
        aud_out <= 12'hA5A;
        aud_drive <= 12'hFF3;
        settle();
        chk("audio oe_n", 12'h00C, pad_oe_n);
        chk("audio out", 12'hA52, pad_out & 12'hFF3);
        @(posedge clk);
        aud_drive <= 12'h000;
        hd_drive <= 7'h00;
        rdy_drive <= 1'b0;
        @(posedge clk);
        far_en <= 12'hFF7;
        far_val <= 12'h1A4;
        settle();
        chk("audio in", 12'h1A0, aud_in);
        chk("host idle", 12'h780, {1'b0, stb2_n, stb1_n, csel_n, astb_n, hd_in});
        @(posedge clk);
        far_val <= 12'hE5B;
        settle();
        chk("audio in", 12'hE53, aud_in);
    endtask

    // A strap change after capture must not move the mode
    task automatic strap_late();
        @(posedge clk);
        strap_en <= 1'b1;
        strap_val <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk("late strap", 12'h000, 12'(host_mode));
    endtask

    // Print counts and verdict, end the run
    task automatic summarize();
        $display("Checks %0d errors %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        {rst, gp0_select, strap_en, strap_val} = 4'b1000;
        {rdy_out, rdy_drive, gp_out, gp_drive} = 4'h0;
        {hd_out, hd_drive} = 14'h0000;
        {aud_out, aud_drive, far_val, far_en} = 48'h0;
        bad_count = 0;
        compares = 0;
        do_reset(1'b0, 1'b0);
        host_out();
        host_in(12'h2AB);
        host_in(12'h554);
        gp_test();
        do_reset(1'b1, 1'b0);
        audio_test();
        gp_test();
        strap_late();
        summarize();
    end

    // Watchdog cuts a hang short
    initial
    begin
        #20000;
        bad_count++;
        $display("Error watchdog expected finish seen timeout");
        summarize();
    end
endmodule // testbench
`default_nettype wire
